/* File: tbc_bank.sv */
// configuration bank and button output logic for the ten touch buttons
// Function
// - one flank membership bit per button, 0-7 in the low register, 8-9 in high bits 1:0.
// - a membership bit of 1 puts the button in the flank suppression group, 0 keeps it out.
// - one toggle enable bit per button, split low and high the same way, 1 enables toggle.
// - with toggle set a button output flips on each new activation instead of following status.
// - two-bit sensitivity code per button, four per register, two in the upper one; 00/01 high, 10 medium, 11 low.
// - button 0 has its own eight-bit debounce register resetting to 01, range 1 to 255.
// - buttons 1 to 9 share one eight-bit debounce register resetting to 01, range 1 to 255.
`timescale 1ns/1ps
module tbc_bank
(
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   // register port from the serial bus engine
   input  wire logic [tbc_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [tbc_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   output logic      [tbc_pkg::DATA_W-1:0]    reg_rdata,
   input  wire logic [2:0]                    device_mode,
   // sensing side
   input  wire logic                          scan_tick,
   input  wire logic [tbc_pkg::NUM_BUTTONS-1:0] touch_raw,
   // results
   output logic      [tbc_pkg::NUM_BUTTONS-1:0] button_active,
   output logic      [tbc_pkg::NUM_BUTTONS-1:0] button_output_n,
   output logic      [tbc_pkg::NUM_BUTTONS-1:0] flank_group_member,
   output logic      [2*tbc_pkg::NUM_BUTTONS-1:0] button_sensitivity_code,
   output tbc_pkg::tbc_level_e [tbc_pkg::NUM_BUTTONS-1:0] button_level
);
   import tbc_pkg::*;

   logic [7:0] flank_lo_r, flank_hi_r, tog_lo_r, tog_hi_r;
   logic [7:0] sens_lo_r, sens_mid_r, sens_up_r, deb_first_r, deb_other_r;
   logic [NUM_BUTTONS-1:0] active_r, out_state_r;
   logic [7:0] cnt_r [NUM_BUTTONS];

   // writes are accepted only in configuration mode; other modes leave settings alone
   wire        wr_ok   = ce & reg_wr & (device_mode == MODE_CONFIG);
   wire        we_flo  = wr_ok & (reg_addr == OFF_FLANK_LO);
   wire        we_fhi  = wr_ok & (reg_addr == OFF_FLANK_HI);
   wire        we_tlo  = wr_ok & (reg_addr == OFF_TOGGLE_LO);
   wire        we_thi  = wr_ok & (reg_addr == OFF_TOGGLE_HI);
   wire        we_slo  = wr_ok & (reg_addr == OFF_SENS_LO);
   wire        we_smi  = wr_ok & (reg_addr == OFF_SENS_MID);
   wire        we_sup  = wr_ok & (reg_addr == OFF_SENS_UP);
   wire        we_d0   = wr_ok & (reg_addr == OFF_DEB_FIRST);
   wire        we_d1   = wr_ok & (reg_addr == OFF_DEB_OTHER);

   always_ff @(posedge clk) begin
      if (rst) begin
         flank_lo_r  <= RST_ZERO;
         flank_hi_r  <= RST_ZERO;
         tog_lo_r    <= RST_ZERO;
         tog_hi_r    <= RST_ZERO;
         sens_lo_r   <= RST_ZERO;
         sens_mid_r  <= RST_ZERO;
         sens_up_r   <= RST_ZERO;
         deb_first_r <= RST_DEB;
         deb_other_r <= RST_DEB;
      end else begin
         if (we_flo) flank_lo_r  <= reg_wdata;
         if (we_fhi) flank_hi_r  <= reg_wdata & HI_MASK;
         if (we_tlo) tog_lo_r    <= reg_wdata;
         if (we_thi) tog_hi_r    <= reg_wdata & HI_MASK;
         if (we_slo) sens_lo_r   <= reg_wdata;
         if (we_smi) sens_mid_r  <= reg_wdata;
         if (we_sup) sens_up_r   <= reg_wdata & SENS_UP_MASK;
         if (we_d0)  deb_first_r <= reg_wdata;
         if (we_d1)  deb_other_r <= reg_wdata;
      end
   end

   // read mux; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= RST_ZERO;
      end else if (ce) begin
         case (reg_addr)
            OFF_FLANK_LO:  reg_rdata <= flank_lo_r;
            OFF_FLANK_HI:  reg_rdata <= flank_hi_r;
            OFF_TOGGLE_LO: reg_rdata <= tog_lo_r;
            OFF_TOGGLE_HI: reg_rdata <= tog_hi_r;
            OFF_SENS_LO:   reg_rdata <= sens_lo_r;
            OFF_SENS_MID:  reg_rdata <= sens_mid_r;
            OFF_SENS_UP:   reg_rdata <= sens_up_r;
            OFF_DEB_FIRST: reg_rdata <= deb_first_r;
            OFF_DEB_OTHER: reg_rdata <= deb_other_r;
            default:       reg_rdata <= RST_ZERO;
         endcase
      end
   end

   wire [NUM_BUTTONS-1:0]   toggle_en = {tog_hi_r[1:0], tog_lo_r};
   wire [2*NUM_BUTTONS-1:0] sens_all  = {sens_up_r[3:0], sens_mid_r, sens_lo_r};
   assign flank_group_member      = {flank_hi_r[1:0], flank_lo_r};
   assign button_sensitivity_code = sens_all;
   assign button_active           = active_r;
   // the pin is active low, so a driven-on button reads 0
   assign button_output_n         = ~out_state_r;

   genvar g;
   generate
      for (g = 0; g < NUM_BUTTONS; g++) begin : g_btn
         wire [1:0] code  = sens_all[2*g +: 2];
         assign button_level[g] = (code == SENS_LOW)    ? TBC_LVL_LOW :
                                  (code == SENS_MEDIUM) ? TBC_LVL_MEDIUM :
                                                          TBC_LVL_HIGH;
         // zero is out of range; treated as one so the button still responds
         wire [7:0] deb_raw = (g == 0) ? deb_first_r : deb_other_r;
         wire [7:0] deb_set = (deb_raw == RST_ZERO) ? DEB_ONE : deb_raw;
         // nine bits so a saturated count cannot wrap below the setting
         wire       reach   = touch_raw[g] &
                              (({1'b0, cnt_r[g]} + {1'b0, DEB_ONE}) >= {1'b0, deb_set});
         wire       act_nxt = touch_raw[g] ? (active_r[g] | reach) : 1'b0;
         wire       rise    = act_nxt & ~active_r[g];
         wire       out_nxt = toggle_en[g] ? (out_state_r[g] ^ rise) : act_nxt;

         always_ff @(posedge clk) begin
            if (rst) begin
               cnt_r[g]       <= RST_ZERO;
               active_r[g]    <= 1'b0;
               out_state_r[g] <= 1'b0;
            end else if (ce && scan_tick) begin
               // saturating count of consecutive touched scans
               if (!touch_raw[g])
                  cnt_r[g] <= RST_ZERO;
               else if (cnt_r[g] != CNT_MAX)
                  cnt_r[g] <= cnt_r[g] + DEB_ONE;
               active_r[g]    <= act_nxt;
               out_state_r[g] <= out_nxt;
            end else if (ce && !toggle_en[g]) begin
               // direct outputs catch up when toggle is switched off between scans
               out_state_r[g] <= active_r[g];
            end
         end
      end
   endgenerate

   // assertions
   property p_deb_reset;
      @(posedge clk) $fell(rst) |-> (deb_first_r == RST_DEB) && (deb_other_r == RST_DEB);
   endproperty
   a_deb_reset: assert property (p_deb_reset) else $error("debounce reset not 01");

   property p_hi_bits;
      @(posedge clk) disable iff (rst) (flank_hi_r & ~HI_MASK) == RST_ZERO;
   endproperty
   a_hi_bits: assert property (p_hi_bits) else $error("flank high reserved bits set");

   property p_flank_wr;
      @(posedge clk) disable iff (rst) we_flo |=> flank_group_member[7:0] == $past(reg_wdata);
   endproperty
   a_flank_wr: assert property (p_flank_wr) else $error("flank write lost");

   property p_mode_gate;
      @(posedge clk) disable iff (rst)
         (reg_wr && device_mode != MODE_CONFIG) |=> $stable(deb_other_r) && $stable(tog_lo_r);
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("write outside config mode");

   property p_tog_wr;
      @(posedge clk) disable iff (rst) we_thi |=> tog_hi_r == ($past(reg_wdata) & HI_MASK);
   endproperty
   a_tog_wr: assert property (p_tog_wr) else $error("toggle high write wrong");

   property p_sens_low;
      @(posedge clk) disable iff (rst)
         sens_lo_r[1:0] == SENS_LOW |-> button_level[0] == TBC_LVL_LOW;
   endproperty
   a_sens_low: assert property (p_sens_low) else $error("sensitivity decode wrong");

   property p_deb1_wr;
      @(posedge clk) disable iff (rst) we_d1 |=> deb_other_r == $past(reg_wdata);
   endproperty
   a_deb1_wr: assert property (p_deb1_wr) else $error("shared debounce write lost");

   property p_release;
      @(posedge clk) disable iff (rst) (ce && scan_tick && !touch_raw[0]) |=> !button_active[0];
   endproperty
   a_release: assert property (p_release) else $error("active without touch");

   property p_direct;
      @(posedge clk) disable iff (rst) !toggle_en[0] && $stable(toggle_en[0]) && !$past(rst)
         && $past(ce) |-> button_output_n[0] == ~button_active[0];
   endproperty
   a_direct: assert property (p_direct) else $error("direct output mismatch");

   // a scan that touches button 0 for the Nth time in a row
   sequence s_reach0;
      ce && scan_tick && touch_raw[0] && (cnt_r[0] == 8'(deb_first_r - DEB_ONE));
   endsequence

   // first touched scan of a toggle button whose shared debounce is one
   sequence s_first_touch1;
      ce && scan_tick && touch_raw[1] && toggle_en[1] && !button_active[1]
         && (deb_other_r == DEB_ONE);
   endsequence

   property p_reach;
      @(posedge clk) disable iff (rst) s_reach0 |=> button_active[0];
   endproperty
   a_reach: assert property (p_reach) else $error("button 0 not active");

   property p_toggle_flip;
      @(posedge clk) disable iff (rst)
         s_first_touch1 |=> button_output_n[1] != $past(button_output_n[1]);
   endproperty
   a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not flip");

   property p_ce_freeze;
      @(posedge clk) disable iff (rst)
         !ce |=> $stable(reg_rdata) && $stable(button_active) && $stable(flank_group_member);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low");

   property p_deb0_wr;
      @(posedge clk) disable iff (rst) we_d0 |=> deb_first_r == $past(reg_wdata);
   endproperty
   a_deb0_wr: assert property (p_deb0_wr) else $error("first debounce write lost");

   property p_flank_hi_wr;
      @(posedge clk) disable iff (rst)
         we_fhi |=> flank_group_member[9:8] == $past(reg_wdata[1:0]);
   endproperty
   a_flank_hi_wr: assert property (p_flank_hi_wr) else $error("flank high write lost");

   property p_sens_up_wr;
      @(posedge clk) disable iff (rst)
         we_sup |=> button_sensitivity_code[19:16] == $past(reg_wdata[3:0]);
   endproperty
   a_sens_up_wr: assert property (p_sens_up_wr) else $error("sensitivity write lost");
endmodule : tbc_bank

/* File: tbc_pkg.sv */
// constants for the touch button configuration bank
package tbc_pkg;
   localparam int          NUM_BUTTONS      = 10;
   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 8;
   // register offsets
   localparam logic [7:0]  OFF_FLANK_LO     = 8'h03;
   localparam logic [7:0]  OFF_FLANK_HI     = 8'h04;
   localparam logic [7:0]  OFF_TOGGLE_LO    = 8'h06;
   localparam logic [7:0]  OFF_TOGGLE_HI    = 8'h07;
   localparam logic [7:0]  OFF_SENS_LO      = 8'h09;
   localparam logic [7:0]  OFF_SENS_MID     = 8'h0a;
   localparam logic [7:0]  OFF_SENS_UP      = 8'h0b;
   localparam logic [7:0]  OFF_DEB_FIRST    = 8'h0e;
   localparam logic [7:0]  OFF_DEB_OTHER    = 8'h0f;
   // reset values and the constant one
   localparam logic [7:0]  RST_ZERO         = 8'h00;
   localparam logic [7:0]  RST_DEB          = 8'h01;
   localparam logic [7:0]  DEB_ONE          = 8'h01;
   // consecutive-scan counter stops here
   localparam logic [7:0]  CNT_MAX          = 8'hff;
   // bits implemented in the high-button registers
   localparam logic [7:0]  HI_MASK          = 8'h03;
   localparam logic [7:0]  SENS_UP_MASK     = 8'h0f;
   // sensitivity codes
   localparam logic [1:0]  SENS_HIGH_A      = 2'b00;
   localparam logic [1:0]  SENS_HIGH_B      = 2'b01;
   localparam logic [1:0]  SENS_MEDIUM      = 2'b10;
   localparam logic [1:0]  SENS_LOW         = 2'b11;
   // operating mode codes
   localparam logic [2:0]  MODE_CONFIG      = 3'b010;
   typedef enum logic [1:0] {TBC_LVL_HIGH, TBC_LVL_MEDIUM, TBC_LVL_LOW} tbc_level_e;
endpackage : tbc_pkg

/* File: tbc_host.sv */
// host-side model that drives the register port of the bank
`timescale 1ns/1ps
module tbc_host (
   // clock
   input  wire logic       clk,
   // register port
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic [2:0]      device_mode,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr    = 8'h00;
      reg_wdata   = 8'h00;
      reg_wr      = 1'b0;
      device_mode = 3'b000;
   end
   // one byte per call, mode travels with the strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] m);
      @(posedge clk);
      device_mode <= m;
      reg_addr    <= a;
      reg_wdata   <= d;
      reg_wr      <= 1'b1;
      @(posedge clk);
      reg_wr      <= 1'b0;
   endtask : wr
   // readback is registered, so wait one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask : rd
endmodule : tbc_host

/* File: tb.sv */
// self-checking bench for the touch button configuration bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
   import tbc_pkg::*;
   logic             clk = 1'b0, rst = 1'b1, ce = 1'b1, scan_tick = 1'b0, wr;
   logic [9:0]       touch_raw = '0, active, out_n, flank, exp_act, exp_out, tog;
   logic [19:0]      sens;
   logic [7:0]       addr, wdata, rdata, d, n0, n1;
   logic [2:0]       mode;
   tbc_level_e [9:0] lvl;
   tbc_level_e       el;
   int               errors = 0, total_checks = 0, cnt [10];
   // addr, write data, readback, reset value
   logic [31:0] rows [10] = '{32'h03A5_A500, 32'h04FF_0300, 32'h065A_5A00, 32'h07FE_0200,
      32'h09E4_E400, 32'h0A1B_1B00, 32'h0BFF_0F00, 32'h0EFF_FF01, 32'h0F80_8001, 32'h0577_0000};
   always #5 clk = ~clk;
   tbc_host tbc_host_inst (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
      .device_mode(mode), .reg_rdata(rdata));
   tbc_bank tbc_bank_inst (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rdata(rdata), .device_mode(mode), .scan_tick(scan_tick),
      .touch_raw(touch_raw), .button_active(active), .button_output_n(out_n),
      .flank_group_member(flank), .button_sensitivity_code(sens), .button_level(lvl));
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // one scan; the bench keeps its own debounce counts
   task automatic tick(input logic [9:0] t);
      logic [9:0] na;
      @(posedge clk);
      touch_raw <= t;
      scan_tick <= 1'b1;
      @(posedge clk);
      scan_tick <= 1'b0;
      #1;
      for (int i = 0; i < 10; i++) begin
         cnt[i] = t[i] ? cnt[i] + 1 : 0;
         na[i]  = cnt[i] >= int'(i == 0 ? n0 : n1);
      end
      exp_out = (~na & ~tog) | ((exp_out ^ (na & ~exp_act)) & tog);
      exp_act = na;
      `CHK("active", exp_act, active)
      `CHK("output", exp_out, out_n)
   endtask : tick
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      results();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1 `CHK("output after reset", 10'h3FF, out_n)
      foreach (rows[i]) begin
         tbc_host_inst.rd(rows[i][31:24], d);
         `CHK("reset value", rows[i][7:0], d)
         tbc_host_inst.wr(rows[i][31:24], rows[i][23:16], MODE_CONFIG);
         tbc_host_inst.rd(rows[i][31:24], d);
         `CHK("readback", rows[i][15:8], d)
      end
      `CHK("flank group", 10'h3A5, flank)
      `CHK("sensitivity", 20'hF_1BE4, sens)
      for (int i = 0; i < 10; i++) begin
         d  = 8'((20'hF_1BE4 >> (2 * i)) & 20'h0_0003);
         el = (d[1:0] == SENS_LOW) ? TBC_LVL_LOW :
              (d[1:0] == SENS_MEDIUM) ? TBC_LVL_MEDIUM : TBC_LVL_HIGH;
         `CHK("level", el, lvl[i])
      end
      // writes outside configuration mode must not land
      tbc_host_inst.wr(OFF_FLANK_LO, 8'h00, 3'b000);
      tbc_host_inst.wr(OFF_FLANK_LO, 8'h00, 3'b001);
      tbc_host_inst.rd(OFF_FLANK_LO, d);
      `CHK("mode refusal", 8'hA5, d)
      tbc_host_inst.wr(OFF_DEB_FIRST, 8'h03, MODE_CONFIG);
      tbc_host_inst.wr(OFF_DEB_OTHER, 8'h01, MODE_CONFIG);
      n0      = 8'h03;
      n1      = 8'h01;
      tog     = 10'h25A;
      exp_act = '0;
      exp_out = 10'h3FF;
      for (int k = 0; k < 8; k++) tick((k == 3 || k == 6) ? 10'h000 : 10'h3FF);
      // clock enable low: neither the release scan nor the write may land
      @(posedge clk);
      ce        <= 1'b0;
      touch_raw <= 10'h000;
      scan_tick <= 1'b1;
      tbc_host_inst.wr(OFF_DEB_FIRST, 8'h07, MODE_CONFIG);
      ce        <= 1'b1;
      scan_tick <= 1'b0;
      #1 `CHK("frozen status", exp_act, active)
      tbc_host_inst.rd(OFF_DEB_FIRST, d);
      `CHK("frozen write", 8'h03, d)
      // reset in mid-run brings settings and outputs back
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 `CHK("output after reset", 10'h3FF, out_n)
      `CHK("flank after reset", 10'h000, flank)
      tbc_host_inst.rd(OFF_DEB_FIRST, d);
      `CHK("debounce after reset", 8'h01, d)
      results();
   end
endmodule : tb
